//--- smp_defs.svh
`ifndef SMP_DEFS_SVH
`define SMP_DEFS_SVH
// Clock periods: system clock and device oscillator
`define SMP_CLK_PERIOD_NS 5
`define SMP_OSC_PERIOD_NS 5
// Serial clock phases: at least two oscillator periods each
`define SMP_SCK_MIN_HALF_NS (2 * `SMP_OSC_PERIOD_NS)
`define SMP_SCK_MIN_HALF_CYC ((`SMP_SCK_MIN_HALF_NS + `SMP_CLK_PERIOD_NS - 1) / `SMP_CLK_PERIOD_NS)
`define SMP_SCK_HALF_CYC 8
// Wait delays (worst listed supply)
`define SMP_WRITE_WAIT_MS 9
`define SMP_ERASE_WAIT_MS 18
`define SMP_MS_TO_CYC(ms) ((ms) * 1000000 / `SMP_CLK_PERIOD_NS)
`define SMP_SYNC_TRIES 32
// Instruction fields
`define SMP_B1_EN 8'hac
`define SMP_B2_EN 8'h53
`define SMP_B2_ERASE 3'h4
`define SMP_B2_LOCK 3'h7
`define SMP_B1_RD_FL 4'h2
`define SMP_B1_WR_FL 4'h4
`define SMP_B1_RD_EE 8'ha0
`define SMP_B1_WR_EE 8'hc0
`define SMP_B1_SIG 8'h30
// Read-back values
`define SMP_POLL_ERASING 8'h80
`define SMP_POLL_WRITING 8'h7f
`define SMP_ERASED_BYTE 8'hff
`define SMP_REFUSED_BYTE 8'h00
// Lock bit pairs {bit2, bit1}; zero means programmed
`define SMP_LOCK_ALL 2'h0
`define SMP_LOCK_NONE 2'h3
`endif

//--- smp_pkg.sv
package smp_pkg;
  // Operations a programmer can issue
  typedef enum logic [2:0] {
    SMP_OP_ENABLE, SMP_OP_ERASE, SMP_OP_RD_FL, SMP_OP_WR_FL,
    SMP_OP_RD_EE, SMP_OP_WR_EE, SMP_OP_LOCK, SMP_OP_SIG
  } smp_op_t;
  // Programmer sequencer states
  typedef enum {
    SMP_H_IDLE, SMP_H_LOW, SMP_H_HIGH, SMP_H_END, SMP_H_WAIT,
    SMP_H_PULSE_HI, SMP_H_PULSE_LO
  } smp_hst_t;
endpackage

//--- smp_link_if.sv
interface smp_link_if;
  logic sck;          // Serial clock, made by the programmer
  logic mosi;         // Data toward the device
  logic miso;         // Data toward the programmer
  logic prog_reset_n; // Device reset pin, low for programming
  modport dev (input sck, input mosi, input prog_reset_n, output miso);
  modport host (output sck, output mosi, output prog_reset_n, input miso);
endinterface

//--- smp_sync.sv
module smp_sync #(
  parameter int W = 1
) (
  // Destination clock and reset
  input logic clk,
  input logic rstn,
  // Level in, synchronised level out
  input logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q; // First stage, read only by the second
  logic [W-1:0] sync_q; // Second stage

  // Two flops; multi-bit use only for flags that may skew apart
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule

//--- smp_dev.sv
// What this block and the programmer do
// - EEPROM busy reads give erasing, then writing values
// - Finished write reads back the written value
// - Programmer waits when EEPROM data equals poll value
// - Flash busy read gives busy value, then data
// - Programmer waits when flash data equals busy value
// - All-ones writes skippable only after chip erase
// - Enable is AC 53 xx xx, reset low
// - AC 100xxxxx erases flash and EEPROM
// - Flash read: 0010H000, 12-bit word address
// - Flash write: 0100H000, address, data byte
// - Byte-select zero low byte, one high
// - EEPROM read: A0, nine-bit address
// - EEPROM write: C0, nine-bit address, data
// - Lock write: AC 111xx21x, zero programs
// - Signature read 30; refused when fully locked
// - Serial clock phases at least two oscillator periods
// - Programmer waits erase delay after chip erase
// - Programmer waits write delay without polling
// - Sample data in rising, change out falling
// - Echo enable second byte; retry up to 32
// - EEPROM write erases location by itself
`include "smp_defs.svh"
module smp_dev #(
  parameter int FL_AW = 12,
  parameter int EE_AW = 9,
  parameter int WRITE_CYC = `SMP_MS_TO_CYC(`SMP_WRITE_WAIT_MS),
  parameter int ERASE_PH_CYC = WRITE_CYC / 2,
  parameter logic [31:0] SIGNATURE = 32'h005a3cc3 // Arbitrary value
) (
  // Device oscillator domain
  input logic clk,
  input logic rstn,
  // Serial link
  smp_link_if.dev link,
  // Status toward the device core
  output logic prog_mode,
  output logic mem_busy
);
  import smp_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (FL_AW < 1 || FL_AW > 12 || EE_AW < 1 || EE_AW > 9) begin : g_bad_aw
    $error("smp_dev: address width out of range");
  end
  if (ERASE_PH_CYC < 1 || ERASE_PH_CYC >= WRITE_CYC) begin : g_bad_cyc
    $error("smp_dev: erase phase must lie inside the write time");
  end

  //////////////////////////////////////////////////////////////////////
  // Serial-clock domain state
  logic sck_rstn;                  // Serial logic runs only while pin low
  logic [4:0] cnt_q;               // Bit position within the instruction
  logic [30:0] sh_q;               // Bits received so far
  logic en_q;                      // Programming enabled
  logic [7:0] rdval_q;             // Answer for the fourth byte
  logic [7:0] out_q;               // Output shifter, falling edge
  logic wr_tgl_q;                  // Flips on each accepted write
  logic pend_ee_q;                 // Pending write targets EEPROM
  logic [FL_AW:0] pend_fl_q;       // Pending flash {word address, H}
  logic [EE_AW-1:0] pend_ee_a_q;   // Pending EEPROM address
  logic [1:0] lock_q;              // Lock bits {2, 1}
  logic busy_s;                    // Write timer running, synchronised
  logic erasing_s;                 // Auto-erase phase, synchronised
  // Nonvolatile arrays; contents are undefined until a chip erase
  logic [15:0] flash_q [2**FL_AW];
  logic [7:0] ee_q [2**EE_AW];

  // Oscillator-domain state
  logic tgl_s;                     // Write toggle, synchronised
  logic tgl_prev_q;                // Toggle seen last cycle
  logic [31:0] tmr_q;              // Write time left
  logic busy_q;                    // Write in progress
  logic erasing_q;                 // EEPROM auto-erase phase
  logic en_s;                      // Enable flag, synchronised
  logic prog_mode_q;               // Registered enable for the core

  //////////////////////////////////////////////////////////////////////
  // Decode of the full word at the last bit
  logic [31:0] word;
  logic last_bit;
  logic is_en;
  logic is_erase;
  logic is_lock;
  logic is_wrfl;
  logic is_wree;
  logic [FL_AW-1:0] wr_fl_a;
  logic [EE_AW-1:0] wr_ee_a;
  logic mem_ok;

  assign sck_rstn = ~link.prog_reset_n;
  assign word = {sh_q, link.mosi};
  assign last_bit = cnt_q == 5'h1f;
  assign is_en = word[31:24] == `SMP_B1_EN
                 && word[23:16] == `SMP_B2_EN;
  assign is_erase = word[31:24] == `SMP_B1_EN
                    && word[23:21] == `SMP_B2_ERASE;
  assign is_lock = word[31:24] == `SMP_B1_EN
                   && word[23:21] == `SMP_B2_LOCK;
  assign is_wrfl = word[31:28] == `SMP_B1_WR_FL
                   && word[26:24] == 3'h0;
  assign is_wree = word[31:24] == `SMP_B1_WR_EE;
  assign wr_fl_a = word[FL_AW+7:8];
  assign wr_ee_a = word[EE_AW+7:8];
  // Writes start only when enabled and no write is still timing
  assign mem_ok = last_bit && en_q && !busy_s;

  //////////////////////////////////////////////////////////////////////
  // Decode of the first three bytes, for reads
  logic [23:0] pre;
  logic rd_fl;
  logic rd_ee;
  logic rd_sig;
  logic [FL_AW-1:0] rd_fl_a;
  logic [EE_AW-1:0] rd_ee_a;
  logic [15:0] fl_word;
  logic [7:0] fl_byte;
  logic fl_hit;
  logic ee_hit;
  logic [7:0] ee_byte;
  logic [7:0] sig_byte;
  logic [7:0] rd_val;

  assign pre = {sh_q[22:0], link.mosi};
  assign rd_fl = pre[23:20] == `SMP_B1_RD_FL && pre[18:16] == 3'h0;
  assign rd_ee = pre[23:16] == `SMP_B1_RD_EE;
  assign rd_sig = pre[23:16] == `SMP_B1_SIG;
  assign rd_fl_a = pre[FL_AW-1:0];
  assign rd_ee_a = pre[EE_AW-1:0];
  assign fl_word = flash_q[rd_fl_a];
  assign fl_byte = pre[19] ? fl_word[15:8] : fl_word[7:0];
  // Reads of the location being written are masked by polling values
  assign fl_hit = busy_s && !pend_ee_q
                  && pend_fl_q == {rd_fl_a, pre[19]};
  assign ee_hit = busy_s && pend_ee_q && pend_ee_a_q == rd_ee_a;
  assign ee_byte = erasing_s ? `SMP_POLL_ERASING
                             : `SMP_POLL_WRITING;
  assign sig_byte = (lock_q == `SMP_LOCK_ALL) ? `SMP_REFUSED_BYTE
                    : SIGNATURE[{pre[1:0], 3'h0} +: 8];
  // Once busy clears the stored value shows through
  assign rd_val = !en_q ? `SMP_REFUSED_BYTE
                  : rd_fl ? (fl_hit ? `SMP_POLL_WRITING : fl_byte)
                  : rd_ee ? (ee_hit ? ee_byte : ee_q[rd_ee_a])
                  : rd_sig ? sig_byte
                  : `SMP_REFUSED_BYTE;

  //////////////////////////////////////////////////////////////////////
  // Input shifter and instruction control, rising edge
  always_ff @(posedge link.sck or negedge sck_rstn) begin
    if (!sck_rstn) begin
      cnt_q <= 5'h00;
      sh_q <= 31'h0;
      en_q <= 1'b0;
      rdval_q <= 8'h00;
      wr_tgl_q <= 1'b0;
      pend_ee_q <= 1'b0;
      pend_fl_q <= '0;
      pend_ee_a_q <= '0;
    end else begin
      // A stray pulse just shifts the framing, which is how resync works
      cnt_q <= cnt_q + 5'h01;
      sh_q <= word[30:0];
      if (cnt_q == 5'h17) begin
        rdval_q <= rd_val;
      end
      if (last_bit && is_en) begin
        en_q <= 1'b1;
      end
      if (mem_ok && (is_wrfl || is_wree)) begin
        wr_tgl_q <= ~wr_tgl_q;
        pend_ee_q <= is_wree;
        pend_fl_q <= {wr_fl_a, word[27]};
        pend_ee_a_q <= wr_ee_a;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Lock bits: erased at power-on and by chip erase
  always_ff @(posedge link.sck or negedge rstn) begin
    if (!rstn) begin
      lock_q <= `SMP_LOCK_NONE;
    end else if (last_bit && en_q && is_erase) begin
      lock_q <= `SMP_LOCK_NONE;
    end else if (last_bit && en_q && is_lock) begin
      // Programming only clears bits; ones leave a bit as it was
      lock_q <= lock_q & word[18:17];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Arrays; no reset, they model nonvolatile cells
  always_ff @(posedge link.sck) begin
    if (last_bit && en_q && is_erase) begin
      // Whole-array clear in one edge; fine for a model of the cells
      for (int i = 0; i < 2**FL_AW; i++) begin
        flash_q[i] <= {2{`SMP_ERASED_BYTE}};
      end
      for (int i = 0; i < 2**EE_AW; i++) begin
        ee_q[i] <= `SMP_ERASED_BYTE;
      end
    end else if (mem_ok && is_wrfl) begin
      if (word[27]) begin
        flash_q[wr_fl_a][15:8] <= word[7:0];
      end else begin
        flash_q[wr_fl_a][7:0] <= word[7:0];
      end
    end else if (mem_ok && is_wree) begin
      // Old value is replaced outright: the auto-erase is implied
      ee_q[wr_ee_a] <= word[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Output shifter, falling edge; reloads at each byte boundary
  always_ff @(negedge link.sck or negedge sck_rstn) begin
    if (!sck_rstn) begin
      out_q <= 8'h00;
    end else if (cnt_q[2:0] == 3'h0) begin
      // Previous byte echoes back; the fourth byte carries the answer
      out_q <= (cnt_q == 5'h18) ? rdval_q : sh_q[7:0];
    end else begin
      out_q <= {out_q[6:0], 1'b0};
    end
  end

  assign link.miso = out_q[7];

  //////////////////////////////////////////////////////////////////////
  // Oscillator-domain write timer
  smp_sync #(.W(1)) u_tgl_sync (
    .clk(clk),
    .rstn(rstn),
    .d(wr_tgl_q),
    .q(tgl_s)
  );

  smp_sync #(.W(1)) u_en_sync (
    .clk(clk),
    .rstn(rstn),
    .d(en_q),
    .q(en_s)
  );

  logic wr_start;
  logic [31:0] tmr_d;
  assign wr_start = tgl_s ^ tgl_prev_q;
  assign tmr_d = wr_start ? 32'(WRITE_CYC)
                 : (tmr_q != 32'h0) ? tmr_q - 32'h1 : tmr_q;

  // Timer and its phase flags; the toggle hides sck pulse widths
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tgl_prev_q <= 1'b0;
      tmr_q <= 32'h0;
      busy_q <= 1'b0;
      erasing_q <= 1'b0;
      prog_mode_q <= 1'b0;
    end else begin
      tgl_prev_q <= tgl_s;
      tmr_q <= tmr_d;
      busy_q <= tmr_d != 32'h0;
      erasing_q <= tmr_d > 32'(WRITE_CYC - ERASE_PH_CYC);
      prog_mode_q <= en_s;
    end
  end

  // Busy flags back to the serial side; a skew of one edge is harmless
  smp_sync #(.W(2)) u_st_sync (
    .clk(link.sck),
    .rstn(sck_rstn),
    .d({busy_q, erasing_q}),
    .q({busy_s, erasing_s})
  );

  assign prog_mode = prog_mode_q;
  assign mem_busy = busy_q;
endmodule

//--- smp_host.sv
`include "smp_defs.svh"
module smp_host #(
  parameter int SCK_HALF = `SMP_SCK_HALF_CYC,
  parameter int WRITE_WAIT = `SMP_MS_TO_CYC(`SMP_WRITE_WAIT_MS),
  parameter int ERASE_WAIT = `SMP_MS_TO_CYC(`SMP_ERASE_WAIT_MS),
  parameter int MAX_TRIES = `SMP_SYNC_TRIES
) (
  // Clock and reset
  input logic clk,
  input logic rstn,
  // Session: holds the device reset pin low
  input logic session,
  // Request
  input logic op_valid,
  input smp_pkg::smp_op_t op,
  input logic [11:0] op_addr,
  input logic op_hi,
  input logic [7:0] op_data,
  // Answer
  output logic op_ready,
  output logic op_done,
  output logic op_fail,
  output logic [7:0] op_rdata,
  // Serial link
  smp_link_if.host link
);
  import smp_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (SCK_HALF < `SMP_SCK_MIN_HALF_CYC || SCK_HALF > 65535) begin : g_bad
    $error("smp_host: serial clock phase too short or too long");
  end
  if (MAX_TRIES < 1 || MAX_TRIES > 63) begin : g_bad_tries
    $error("smp_host: retry count out of range");
  end

  //////////////////////////////////////////////////////////////////////
  // Instruction builder
  function automatic logic [31:0] build(smp_op_t o, logic [11:0] a,
                                        logic h, logic [7:0] d);
    logic [31:0] w;
    w = 32'h0;
    case (o)
      SMP_OP_ENABLE: w = {`SMP_B1_EN, `SMP_B2_EN, 16'h0};
      SMP_OP_ERASE: w = {`SMP_B1_EN, `SMP_B2_ERASE, 21'h0};
      SMP_OP_RD_FL: w = {`SMP_B1_RD_FL, h, 7'h0, a[11:0], 8'h0};
      SMP_OP_WR_FL: w = {`SMP_B1_WR_FL, h, 7'h0, a[11:0], d};
      SMP_OP_RD_EE: w = {`SMP_B1_RD_EE, 7'h0, a[8:0], 8'h0};
      SMP_OP_WR_EE: w = {`SMP_B1_WR_EE, 7'h0, a[8:0], d};
      SMP_OP_LOCK: w = {`SMP_B1_EN, `SMP_B2_LOCK, 2'h3, d[1:0], 1'h1,
                        16'h0};
      SMP_OP_SIG: w = {`SMP_B1_SIG, 14'h0, a[1:0], 8'h0};
      default: w = 32'h0;
    endcase
    return w;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // State
  smp_hst_t st_q;
  logic [15:0] div_q;     // Phase timer
  logic [4:0] bit_q;      // Bits sent
  logic [31:0] tx_q;      // Bits still to send
  logic [31:0] rx_q;      // Bits received
  logic sck_q;
  logic mosi_q;
  logic rst_pin_q;
  logic [31:0] tmr_q;     // Wait or poll timeout
  logic [5:0] tries_q;    // Enable attempts
  smp_op_t op_q;
  logic [11:0] addr_q;
  logic hi_q;
  logic [7:0] data_q;
  logic poll_q;           // Sending read-back instructions
  logic erased_q;         // Chip erase done this run
  logic ready_q;
  logic done_q;
  logic fail_q;
  logic [7:0] rdata_q;
  logic miso_s;

  smp_sync #(.W(1)) u_miso_sync (
    .clk(clk),
    .rstn(rstn),
    .d(link.miso),
    .q(miso_s)
  );

  // Decodes used by the sequencer
  logic phase_end;
  logic is_wr;
  logic skip_ff;
  logic no_poll;
  logic [31:0] req_word;
  logic [31:0] poll_word;
  assign phase_end = div_q == 16'(SCK_HALF - 1);
  assign is_wr = op == SMP_OP_WR_FL || op == SMP_OP_WR_EE;
  // Erased cells already hold all-ones, so those writes can go
  assign skip_ff = is_wr && erased_q && op_data == `SMP_ERASED_BYTE;
  // Data equal to a poll value cannot be told from busy
  assign no_poll = data_q == `SMP_POLL_WRITING
                   || (op_q == SMP_OP_WR_EE
                       && data_q == `SMP_POLL_ERASING);
  assign req_word = build(op, op_addr, op_hi, op_data);
  assign poll_word = build(op_q == SMP_OP_WR_FL ? SMP_OP_RD_FL
                           : SMP_OP_RD_EE, addr_q, hi_q, 8'h0);

  //////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= SMP_H_IDLE;
      div_q <= 16'h0;
      bit_q <= 5'h0;
      tx_q <= 32'h0;
      rx_q <= 32'h0;
      sck_q <= 1'b0;
      mosi_q <= 1'b0;
      rst_pin_q <= 1'b1;
      tmr_q <= 32'h0;
      tries_q <= 6'h0;
      op_q <= SMP_OP_ENABLE;
      addr_q <= 12'h0;
      hi_q <= 1'b0;
      data_q <= 8'h0;
      poll_q <= 1'b0;
      erased_q <= 1'b0;
      ready_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      rdata_q <= 8'h0;
    end else begin
      rst_pin_q <= ~session;
      done_q <= 1'b0;
      div_q <= div_q + 16'h1;
      if (tmr_q != 32'h0) begin
        tmr_q <= tmr_q - 32'h1;
      end
      case (st_q)
        SMP_H_IDLE: begin
          ready_q <= 1'b1;
          div_q <= 16'h0;
          if (op_valid && skip_ff) begin
            done_q <= 1'b1;
            fail_q <= 1'b0;
          end else if (op_valid) begin
            ready_q <= 1'b0;
            op_q <= op;
            addr_q <= op_addr;
            hi_q <= op_hi;
            data_q <= op_data;
            tx_q <= req_word;
            mosi_q <= req_word[31];
            bit_q <= 5'h0;
            poll_q <= 1'b0;
            tries_q <= 6'h0;
            st_q <= SMP_H_LOW;
          end
        end
        // Low phase; miso is sampled late, just before the rise
        SMP_H_LOW: if (phase_end) begin
          rx_q <= {rx_q[30:0], miso_s};
          sck_q <= 1'b1;
          div_q <= 16'h0;
          st_q <= SMP_H_HIGH;
        end
        // High phase; next data bit goes out on the fall
        SMP_H_HIGH: if (phase_end) begin
          sck_q <= 1'b0;
          div_q <= 16'h0;
          tx_q <= {tx_q[30:0], 1'b0};
          mosi_q <= tx_q[30];
          bit_q <= bit_q + 5'h1;
          st_q <= (bit_q == 5'h1f) ? SMP_H_END : SMP_H_LOW;
        end
        SMP_H_END: begin
          div_q <= 16'h0;
          bit_q <= 5'h0;
          st_q <= SMP_H_IDLE;
          done_q <= 1'b1;
          fail_q <= 1'b0;
          case (op_q)
            SMP_OP_ENABLE: if (rx_q[15:8] != `SMP_B2_EN) begin
              done_q <= tries_q == 6'(MAX_TRIES - 1);
              fail_q <= tries_q == 6'(MAX_TRIES - 1);
              tries_q <= tries_q + 6'h1;
              if (tries_q != 6'(MAX_TRIES - 1)) begin
                st_q <= SMP_H_PULSE_HI;
              end
            end
            SMP_OP_ERASE: begin
              done_q <= 1'b0;
              tmr_q <= 32'(ERASE_WAIT);
              st_q <= SMP_H_WAIT;
            end
            SMP_OP_WR_FL, SMP_OP_WR_EE: begin
              if (!poll_q && no_poll) begin
                done_q <= 1'b0;
                tmr_q <= 32'(WRITE_WAIT);
                st_q <= SMP_H_WAIT;
              end else if (!poll_q || (rx_q[7:0] != data_q
                                       && tmr_q != 32'h0)) begin
                // Poll until the value reads back, bounded by the delay
                done_q <= 1'b0;
                poll_q <= 1'b1;
                if (!poll_q) begin
                  tmr_q <= 32'(WRITE_WAIT);
                end
                tx_q <= poll_word;
                mosi_q <= poll_word[31];
                st_q <= SMP_H_LOW;
              end
            end
            SMP_OP_RD_FL, SMP_OP_RD_EE, SMP_OP_SIG: rdata_q <= rx_q[7:0];
            default: rdata_q <= rdata_q;
          endcase
        end
        SMP_H_WAIT: if (tmr_q == 32'h0) begin
          erased_q <= erased_q || op_q == SMP_OP_ERASE;
          done_q <= 1'b1;
          st_q <= SMP_H_IDLE;
        end
        // Extra clock pulse slips the device framing by one bit
        SMP_H_PULSE_HI: begin
          sck_q <= 1'b1;
          if (phase_end) begin
            sck_q <= 1'b0;
            div_q <= 16'h0;
            st_q <= SMP_H_PULSE_LO;
          end
        end
        SMP_H_PULSE_LO: if (phase_end) begin
          tx_q <= build(SMP_OP_ENABLE, 12'h0, 1'b0, 8'h0);
          mosi_q <= 1'b1;
          div_q <= 16'h0;
          st_q <= SMP_H_LOW;
        end
        default: st_q <= SMP_H_IDLE;
      endcase
    end
  end

  assign link.sck = sck_q;
  assign link.mosi = mosi_q;
  assign link.prog_reset_n = rst_pin_q;
  assign op_ready = ready_q;
  assign op_done = done_q;
  assign op_fail = fail_q;
  assign op_rdata = rdata_q;
endmodule

//--- smp_link_chk.sv
module smp_link_chk (
  // Clock and reset
  input logic clk,
  input logic rstn,
  // Link wires
  input logic sck,
  input logic mosi,
  input logic miso,
  input logic prog_reset_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////
  // Serial clock edges, used by several properties
  sequence s_rise;
    $rose(sck);
  endsequence
  sequence s_fall;
    $fell(sck);
  endsequence
  // Each phase lasts two clocks at least, and high ends in time
  property p_sck_hi;
    s_rise |-> sck [*2];
  endproperty
  a_sck_hi: assert property (p_sck_hi)
    else $error("sck high phase too short");
  property p_sck_lo;
    s_fall |-> !sck [*2];
  endproperty
  a_sck_lo: assert property (p_sck_lo)
    else $error("sck low phase too short");
  property p_sck_end;
    s_rise |-> ##[1:16] !sck;
  endproperty
  a_sck_end: assert property (p_sck_end)
    else $error("sck high phase too long");
  // Data wires hold while sck is high; they move only while it is low
  property p_mosi_hold;
    sck && $past(sck) |-> $stable(mosi);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("mosi moved while sck high");
  property p_miso_hold;
    sck && $past(sck) |-> $stable(miso);
  endproperty
  a_miso_hold: assert property (p_miso_hold)
    else $error("miso moved while sck high");
  // Outside a session the link stays quiet
  property p_idle_sck;
    prog_reset_n |-> !sck;
  endproperty
  a_idle_sck: assert property (p_idle_sck)
    else $error("sck toggles outside a session");
  property p_idle_miso;
    prog_reset_n && $past(prog_reset_n) |-> !miso;
  endproperty
  a_idle_miso: assert property (p_idle_miso)
    else $error("miso driven outside a session");
  property p_start;
    $fell(prog_reset_n) |-> !sck [*2];
  endproperty
  a_start: assert property (p_start)
    else $error("sck not low at session start");
endmodule

//--- smp_tb_top.sv
module smp_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import smp_pkg::*;
  // Arbitrary signature, handed to the device
  localparam logic [31:0] SIG = 32'h005a3cc3;
  logic clk = 0;
  // Starts high so that the asynchronous resets see a falling edge
  logic rstn = 1;
  logic session = 0;
  logic op_valid = 0;
  smp_op_t op = SMP_OP_ENABLE;
  logic [11:0] op_addr = 12'h000;
  logic op_hi = 0;
  logic [7:0] op_data = 8'h00;
  logic op_ready, op_done, op_fail, prog_mode, mem_busy;
  logic [7:0] op_rdata;
  int mismatches = 0;
  int checked = 0;
  int op_cycles = 0; // Cycles from request to done
  // One clock feeds both ends; sck comes from the host divider
  always #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////
  smp_link_if link ();
  // Busy spans several polls, so both poll values show on the wire
  smp_host #(.WRITE_WAIT(1800), .ERASE_WAIT(300)) i_smp_host (.clk, .rstn,
    .session, .op_valid, .op, .op_addr, .op_hi, .op_data, .op_ready,
    .op_done, .op_fail, .op_rdata, .link(link));
  smp_dev #(.WRITE_CYC(1600), .ERASE_PH_CYC(800), .SIGNATURE(SIG))
    i_smp_dev (.clk, .rstn, .link(link), .prog_mode, .mem_busy);
  smp_link_chk i_smp_link_chk (.clk, .rstn, .sck(link.sck),
    .mosi(link.mosi), .miso(link.miso), .prog_reset_n(link.prog_reset_n));
  // Fourth byte of each instruction as it passes on miso
  logic [4:0] nbit = 5'h00;
  logic [7:0] ans = 8'h00;
  wire [7:0] byte4 = {ans[6:0], link.miso};
  int n80 = 0;
  int n7f = 0;
  always @(posedge link.sck) begin
    nbit <= nbit + 5'h01;
    ans <= byte4;
    if (nbit == 5'h1f && byte4 == 8'h80) n80 <= n80 + 1;
    if (nbit == 5'h1f && byte4 == 8'h7f) n7f <= n7f + 1;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
    input string what);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // Issue one request and wait, bounded, for its done pulse
  task automatic run(input smp_op_t o, input logic [11:0] a,
    input logic h, input logic [7:0] d);
    do begin
      @(posedge clk);
      #1;
    end while (op_ready !== 1'b1);
    op = o;
    op_addr = a;
    op_hi = h;
    op_data = d;
    op_valid = 1;
    op_cycles = 0;
    // A skipped write answers in the very cycle it is taken
    do begin
      @(posedge clk);
      #1;
      op_valid = 0;
      op_cycles++;
    end while (op_done !== 1'b1 && op_cycles < 4000);
    if (op_cycles >= 4000) chk(8'h01, 8'h00, "op_done timeout");
  endtask
  task automatic rd(input smp_op_t o, input logic [11:0] a,
    input logic h, input logic [7:0] exp);
    run(o, a, h, 8'h00);
    chk(op_rdata, exp, "op_rdata");
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_enable;
    session = 1;
    repeat (8) @(posedge clk);
    rd(SMP_OP_RD_EE, 12'h005, 0, 8'h00);
    chk({7'h00, prog_mode}, 8'h00, "prog_mode");
    run(SMP_OP_ENABLE, 12'h000, 0, 8'h00);
    chk({7'h00, op_fail}, 8'h00, "op_fail");
    chk({7'h00, prog_mode}, 8'h01, "prog_mode");
    $display("t_enable done");
  endtask
  task automatic t_erase;
    run(SMP_OP_ERASE, 12'h000, 0, 8'h00);
    rd(SMP_OP_RD_FL, 12'habc, 0, 8'hff);
    rd(SMP_OP_RD_FL, 12'habc, 1, 8'hff);
    rd(SMP_OP_RD_EE, 12'h1ff, 0, 8'hff);
    $display("t_erase done");
  endtask
  task automatic t_flash;
    int a80;
    int a7f;
    a80 = n80;
    a7f = n7f;
    run(SMP_OP_WR_FL, 12'habc, 0, 8'h3c);
    chk(8'(n80 - a80), 8'h00, "erasing polls");
    chk(8'(n7f - a7f), 8'h03, "busy polls");
    run(SMP_OP_WR_FL, 12'h2bc, 0, 8'hff);
    chk(8'(op_cycles), 8'h01, "skip cycles");
    run(SMP_OP_WR_FL, 12'habc, 1, 8'hc5);
    rd(SMP_OP_RD_FL, 12'habc, 0, 8'h3c);
    rd(SMP_OP_RD_FL, 12'habc, 1, 8'hc5);
    rd(SMP_OP_RD_FL, 12'h2bc, 0, 8'hff);
    run(SMP_OP_WR_FL, 12'h0a1, 0, 8'h7f);
    rd(SMP_OP_RD_FL, 12'h0a1, 0, 8'h7f);
    $display("t_flash done");
  endtask
  task automatic t_eeprom;
    int a80;
    int a7f;
    a80 = n80;
    a7f = n7f;
    run(SMP_OP_WR_EE, 12'h123, 0, 8'h5a);
    chk(8'(n80 - a80), 8'h01, "erasing polls");
    chk(8'(n7f - a7f), 8'h02, "writing polls");
    chk({7'h00, mem_busy}, 8'h00, "mem_busy");
    rd(SMP_OP_RD_EE, 12'h123, 0, 8'h5a);
    rd(SMP_OP_RD_EE, 12'h023, 0, 8'hff);
    run(SMP_OP_WR_EE, 12'h123, 0, 8'h80);
    rd(SMP_OP_RD_EE, 12'h123, 0, 8'h80);
    run(SMP_OP_WR_EE, 12'h023, 0, 8'h7f);
    rd(SMP_OP_RD_EE, 12'h023, 0, 8'h7f);
    $display("t_eeprom done");
  endtask
  // Signature bytes, then lock modes; erase unlocks again
  task automatic t_lock;
    for (int i = 0; i < 4; i++) begin
      rd(SMP_OP_SIG, 12'(i), 0, SIG[8*i+:8]);
    end
    run(SMP_OP_LOCK, 12'h000, 0, 8'h02);
    rd(SMP_OP_SIG, 12'h001, 0, SIG[15:8]);
    run(SMP_OP_LOCK, 12'h000, 0, 8'h00);
    rd(SMP_OP_SIG, 12'h001, 0, 8'h00);
    run(SMP_OP_ERASE, 12'h000, 0, 8'h00);
    rd(SMP_OP_SIG, 12'h002, 0, SIG[23:16]);
    $display("t_lock done");
  endtask
  ////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Watchdog, well beyond the expected run of some 27k cycles
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    finish_test();
  end
  // Main sequence
  initial begin
    #1;
    rstn = 0;
    repeat (16) @(posedge clk);
    #1;
    rstn = 1;
    t_enable();
    t_erase();
    t_flash();
    t_eeprom();
    t_lock();
    finish_test();
  end
endmodule
